// *** ssc_slave_channel.sv ***
// Slave serial channel: receive-only or full-duplex with external clock
//
// Notes on behaviour
// - Shift clock comes only from master; channel shifts on received edges.
// - Receive-only mode raises transfer-end and overrun events, never buffer-empty.
// - Full duplex: transfer-end in single mode, buffer-empty in continuous mode.
// - Overrun flag sets when a frame completes while received data unread.
// - Frame length is seven or eight bits by configuration.
// - Serial clock is sampled; master must stay at or below clock over six.
// - Data phase 0: data starts at first edge; 1: half period earlier.
// - Clock polarity 0 takes serial clock as is, 1 inverts it.
// - Bit order selectable, most or least significant bit first.
// - Writing transmit data while buffer full replaces the pending value.
// - Reading data register while transmit data pending returns it harmlessly.
// - Single/continuous bit may change during operation before the last bit.
// - Reading received data clears buffer full and readies next reception.
// - Writing ones to the flag-clear register clears matching error flags.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ssc_slave_channel
    import ssc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Serial pins
    input  wire logic              serial_clock_in_ch0,
    input  wire logic              serial_data_in_ch0,
    output logic                   serial_data_out_ch0,
    // Interrupt
    output logic                   xfer_irq_ch0
);

    // Bit position within the frame for a given bit count
    function automatic logic [2:0] bit_idx(input logic [2:0] c, input ssc_cfg_t f);
        logic [2:0] top;
        top = f.len7 ? LAST_IDX_7 : LAST_IDX_8;
        return f.lsb ? c : 3'(top - c);
    endfunction : bit_idx

    ssc_req_t          req;
    ssc_cfg_t          cfg_q;
    logic              en_q;
    logic              cont_q;
    logic              tx_full_q;
    logic              rx_full_q;
    logic              ovf_q;
    logic              in_frame_q;
    logic [2:0]        cnt_q;
    logic [DATA_W-1:0] tx_buf_q;
    logic [DATA_W-1:0] tx_sh_q;
    logic [DATA_W-1:0] rx_sh_q;
    logic [DATA_W-1:0] rx_buf_q;
    logic [IRQ_W-1:0]  irq_st_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              k_prev_q;
    logic [1:0]        pins_s;
    logic              sclk_s;
    logic              sdi_s;
    logic              k;
    logic              rise;
    logic              fall;
    logic              sample;
    logic              drive;
    logic              last;
    logic              done;
    logic              load;
    logic              wr_data;
    logic              rd_rx;
    logic              ev_xfer;
    logic              ev_bempty;
    logic              ev_ovf;
    logic [2:0]        last_idx;
    logic [DATA_W-1:0] tx_src;
    logic [DATA_W-1:0] rx_new;
    logic [IRQ_W-1:0]  ev_vec;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Pin synchronisers; edges are only seen at up to clock over six
    ssc_sync #(
        .W (2)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in ({serial_clock_in_ch0, serial_data_in_ch0}),
        .sync_out (pins_s)
    );
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // Polarity applied, idle level high after correction
    assign k    = sclk_s ^ cfg_q.ckp;
    assign rise = k & ~k_prev_q;
    assign fall = ~k & k_prev_q;

    // Phase picks which edge samples and which drives
    assign sample   = en_q & (cfg_q.dap ? fall : rise);
    assign drive    = en_q & (cfg_q.dap ? rise : fall);
    assign last_idx = cfg_q.len7 ? LAST_IDX_7 : LAST_IDX_8;
    assign last     = (cnt_q == last_idx);
    assign done     = sample & last;

    // Register strobes
    assign wr_data = req.wr & (req.addr == OFS_DATA) & cfg_q.fdx;
    assign rd_rx   = req.rd & (req.addr == OFS_DATA) & ~tx_full_q;

    // Buffer moves into shifter between frames; needs data before clocking
    assign load   = en_q & cfg_q.fdx & tx_full_q & (~in_frame_q | done);
    assign tx_src = load ? tx_buf_q : tx_sh_q;

    // Events; mode bit read live so a late change still applies
    assign ev_xfer   = done & (~cfg_q.fdx | ~cont_q);
    assign ev_bempty = load & cfg_q.fdx & cont_q;
    assign ev_ovf    = done & rx_full_q & ~rd_rx;

    always_comb begin
        ev_vec             = '0;
        ev_vec[IRQ_XFER]   = ev_xfer;
        ev_vec[IRQ_BEMPTY] = ev_bempty;
        ev_vec[IRQ_OVF]    = ev_ovf;
    end

    // Received word with the current bit merged in
    always_comb begin
        rx_new                      = rx_sh_q;
        rx_new[bit_idx(cnt_q, cfg_q)] = sdi_s;
        if (cfg_q.len7) begin
            rx_new[DATA_W-1] = 1'b0;
        end
    end

    // Edge detector history
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            k_prev_q <= 1'b1;
        end else begin
            k_prev_q <= k;
        end
    end

    // Configuration and mode registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_q      <= RST_CFG;
            en_q       <= 1'b0;
            cont_q     <= 1'b0;
            irq_mask_q <= RST_IRQ;
        end else if (req.wr) begin
            if (req.addr == OFS_CONFIG) begin
                cfg_q <= ssc_cfg_t'(req.wdata[4:0]);
            end
            if (req.addr == OFS_MODE) begin
                en_q   <= req.wdata[MD_EN];
                cont_q <= req.wdata[MD_CONT];
            end
            if (req.addr == OFS_IRQ_MASK) begin
                irq_mask_q <= req.wdata[IRQ_W-1:0];
            end
        end
    end

    // Bit counter and frame tracking; disable returns to idle
    always_ff @(posedge clk) begin
        if (!rst_b || !en_q) begin
            cnt_q      <= 3'h0;
            in_frame_q <= 1'b0;
        end else if (done) begin
            cnt_q      <= 3'h0;
            in_frame_q <= 1'b0;
        end else if (sample) begin
            cnt_q      <= 3'(cnt_q + 3'h1);
            in_frame_q <= 1'b1;
        end
    end

    // Receive shifter and receive buffer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_sh_q  <= RST_DATA;
            rx_buf_q <= RST_DATA;
        end else if (sample) begin
            rx_sh_q <= rx_new;
            if (done) begin
                rx_buf_q <= rx_new;
            end
        end
    end

    // Receive buffer full; frame end wins over a read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_full_q <= 1'b0;
        end else if (done) begin
            rx_full_q <= 1'b1;
        end else if (rd_rx) begin
            rx_full_q <= 1'b0;
        end
    end

    // Transmit buffer; a write always overwrites
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_buf_q  <= RST_DATA;
            tx_full_q <= 1'b0;
        end else if (wr_data) begin
            tx_buf_q  <= req.wdata;
            tx_full_q <= 1'b1;
        end else if (load) begin
            tx_full_q <= 1'b0;
        end
    end

    // Transmit shifter and data output
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_sh_q <= RST_DATA;
            serial_data_out_ch0 <= 1'b0;
        end else begin
            tx_sh_q <= tx_src;
            if (drive || (load && cfg_q.dap)) begin
                serial_data_out_ch0 <= tx_src[bit_idx(done ? 3'h0 : cnt_q, cfg_q)];
            end
        end
    end

    // Overrun flag; a new overrun wins over a clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ovf_q <= 1'b0;
        end else if (ev_ovf) begin
            ovf_q <= 1'b1;
        end else if (req.wr && req.addr == OFS_FLAG_CLR && req.wdata[ST_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_st_q <= RST_IRQ;
        end else if (req.wr && req.addr == OFS_IRQ_ST) begin
            irq_st_q <= (irq_st_q & ~req.wdata[IRQ_W-1:0]) | ev_vec;
        end else begin
            irq_st_q <= irq_st_q | ev_vec;
        end
    end

    // Level interrupt output
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            xfer_irq_ch0 <= 1'b0;
        end else begin
            xfer_irq_ch0 <= |(irq_st_q & irq_mask_q);
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= RST_DATA;
        end else if (req.rd) begin
            unique case (req.addr)
                OFS_DATA:     reg_rdata <= tx_full_q ? tx_buf_q : rx_buf_q;
                OFS_STATUS:   reg_rdata <= {5'h00, in_frame_q, ovf_q, tx_full_q | rx_full_q};
                OFS_MODE:     reg_rdata <= {6'h00, cont_q, en_q};
                OFS_CONFIG:   reg_rdata <= {3'h0, cfg_q};
                OFS_IRQ_ST:   reg_rdata <= {5'h00, irq_st_q};
                OFS_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_q};
                default:      reg_rdata <= RST_DATA;
            endcase
        end else begin
            reg_rdata <= RST_DATA;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_rxonly_no_bempty: assert property (!cfg_q.fdx |-> !ev_bempty)
        else $error("buffer-empty event in receive-only mode");
    a_irq_src_mode: assert property (ev_xfer |-> !(cfg_q.fdx && cont_q))
        else $error("transfer-end event in continuous full duplex");
    a_overrun_set: assert property (done && rx_full_q && !rd_rx
                                    |=> ovf_q && rx_full_q)
        else $error("overrun not flagged");
    a_frame_len: assert property (done |-> cnt_q == (cfg_q.len7 ? 3'h6 : 3'h7))
        else $error("frame ended at wrong bit count");
    a_tx_overwrite: assert property (wr_data
                                     |=> tx_full_q && tx_buf_q == $past(req.wdata))
        else $error("transmit write not taken");
    a_tx_readback: assert property (req.rd && req.addr == OFS_DATA && tx_full_q
                                    |=> reg_rdata == $past(tx_buf_q))
        else $error("pending transmit data not returned");
    a_rx_read_clr: assert property (rd_rx && !done |=> !rx_full_q)
        else $error("read did not free receive buffer");
    a_flag_clear: assert property (req.wr && req.addr == OFS_FLAG_CLR
                                   && req.wdata[ST_OVF] && !ev_ovf |=> !ovf_q)
        else $error("overrun flag not cleared");
    a_bempty_load: assert property (load && cont_q
                                    |-> ev_bempty ##1 (!tx_full_q || $past(wr_data)))
        else $error("buffer-empty missing at load");
    a_dap_first: assert property (load && cfg_q.dap && !drive
        |=> serial_data_out_ch0 == $past(tx_buf_q[bit_idx(3'h0, cfg_q)]))
        else $error("first bit not presented early");
    a_irq_level: assert property (|(irq_st_q & irq_mask_q) |=> xfer_irq_ch0)
        else $error("interrupt output not raised");

    c_overrun:  cover property (ev_ovf);
    c_cont_ld:  cover property (ev_bempty ##[1:200] done);
    c_len7:     cover property (done && cfg_q.len7);
    c_dap1_end: cover property (done && cfg_q.dap && cfg_q.lsb);

endmodule : ssc_slave_channel

`default_nettype wire

// *** ssc_pkg.sv ***
// Shared constants and carrier types for the slave serial channel
package ssc_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_DATA     = 3'h0;  // channel_data_reg
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h1;  // channel_status_reg
    localparam logic [ADDR_W-1:0] OFS_FLAG_CLR = 3'h2;  // flag_clear_trigger
    localparam logic [ADDR_W-1:0] OFS_MODE     = 3'h3;  // channel_mode_reg
    localparam logic [ADDR_W-1:0] OFS_CONFIG   = 3'h4;  // channel_comm_config
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST   = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h6;

    // Status register bit positions
    localparam int unsigned ST_BFF  = 0;
    localparam int unsigned ST_OVF  = 1;
    localparam int unsigned ST_BUSY = 2;

    // Mode register bit positions
    localparam int unsigned MD_EN   = 0;
    localparam int unsigned MD_CONT = 1;

    // Interrupt status and mask bit positions
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_XFER   = 0;
    localparam int unsigned IRQ_BEMPTY = 1;
    localparam int unsigned IRQ_OVF    = 2;

    // Frame lengths as last bit index
    localparam logic [2:0] LAST_IDX_8 = 3'h7;
    localparam logic [2:0] LAST_IDX_7 = 3'h6;

    // Least ratio of operation clock to serial clock
    localparam int unsigned SCK_MIN_DIV = 6;

    // Synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    // Reset values
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
    localparam logic [IRQ_W-1:0]  RST_IRQ  = 3'h0;

    // Channel configuration, bit 0 is data phase
    typedef struct packed {
        logic fdx;    // 1: transmit and receive, 0: receive only
        logic len7;   // 1: seven-bit frames
        logic lsb;    // 1: least significant bit first
        logic ckp;    // clock_polarity_sel
        logic dap;    // data_phase_sel
    } ssc_cfg_t;

    localparam ssc_cfg_t RST_CFG = 5'h00;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ssc_req_t;

endpackage : ssc_pkg

// *** ssc_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module ssc_sync
    import ssc_pkg::*;
#(
    parameter int unsigned W = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : ssc_sync

`default_nettype wire

// *** ssc_master_model.sv ***
// Behavioural external master for the slave serial channel
`timescale 1ns/1ps
`default_nettype none
module ssc_master_model
    import ssc_pkg::*;
(
    // Serial pins
    output var logic sclk,
    output var logic mosi,
    input  wire logic miso
);
    // Clock idles high for polarity 0
    initial begin
        sclk = 1'b1;
        mosi = 1'b0;
    end
    // Park the clock at its idle level
    task automatic park(input logic ckp);
        sclk = ~ckp;
    endtask : park
    // One frame, 62.5 ns half period stays under clk/6
    task automatic xfer(input logic [7:0] tx, input ssc_cfg_t c, output logic [7:0] rx);
        int n;
        int b;
        n = c.len7 ? 7 : 8;
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            b = c.lsb ? i : n - 1 - i;
            if (c.dap) mosi = tx[b];
            #62.5 sclk = c.ckp;
            if (c.dap) rx[b] = miso;
            else mosi = tx[b];
            #62.5 sclk = ~c.ckp;
            if (!c.dap) rx[b] = miso;
        end
        // Data line no longer holds the last bit
        #62.5 mosi = ~mosi;
    endtask : xfer
endmodule : ssc_master_model
`default_nettype wire

// *** tb_spi_slave_rx_txrx_channel.sv ***
// Self-checking bench for the slave serial channel
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_rx_txrx_channel
    import ssc_pkg::*;
;
    // Clock, reset, register port and pins
    logic              clk       = 1'b0;
    logic              rst_b     = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = 3'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              sclk;
    logic              mosi;
    logic              miso;
    logic              irq;
    logic [7:0]        v;
    logic [7:0]        r;
    int                n_errors  = 0;
    int                n_tests   = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    ssc_slave_channel DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_clock_in_ch0(sclk), .serial_data_in_ch0(mosi),
        .serial_data_out_ch0(miso), .xfer_irq_ch0(irq));
    ssc_master_model mst (.sclk(sclk), .mosi(mosi), .miso(miso));

    // Verdict and end of run
    task automatic report_and_stop();
        $display("counts: errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Compare one value
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    // Register write, one strobe cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Register read, data taken the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    // Read and compare
    task automatic rdc(input string nm, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] g;
        rd(a, g);
        chk(nm, e, g);
    endtask : rdc
    // Bounded wait for the interrupt line
    task automatic wait_irq();
        for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
        if (irq !== 1'b1) begin
            $display("BAD irq wait expected 1 seen %b", irq);
            n_errors++;
            report_and_stop();
        end
    endtask : wait_irq
    // Disable, park clock, configure, enable: disable resets only the bit counter and frame state
    task automatic setup(input ssc_cfg_t c, input logic [7:0] md);
        wr(OFS_MODE, 8'h00);
        mst.park(c.ckp);
        wr(OFS_CONFIG, {3'h0, c});
        wr(OFS_MODE, md);
    endtask : setup
    // Reset values and an unmapped index
    task automatic t_reset();
        rdc("status", OFS_STATUS, 8'h00);
        rdc("config", OFS_CONFIG, 8'h00);
        rdc("mode", OFS_MODE, 8'h00);
        rdc("mask", OFS_IRQ_MASK, 8'h00);
        rdc("unmapped", 3'h7, 8'h00);
    endtask : t_reset
    // Receive only with continuous bit set; mask and clear
    task automatic t_rx_only();
        wr(OFS_IRQ_MASK, 8'h07);
        rdc("mask", OFS_IRQ_MASK, 8'h07);
        setup(5'h00, 8'h03);
        mst.xfer(8'hA5, 5'h00, r);
        wait_irq();
        rdc("irq st", OFS_IRQ_ST, 8'h01);
        rdc("status", OFS_STATUS, 8'h01);
        wr(OFS_IRQ_MASK, 8'h06);
        repeat (2) @(posedge clk);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(OFS_IRQ_MASK, 8'h07);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 8'h01, {7'h00, irq});
        rdc("rx data", OFS_DATA, 8'hA5);
        rdc("status", OFS_STATUS, 8'h00);
        wr(OFS_IRQ_ST, 8'h07);
        repeat (2) @(posedge clk);
        chk("irq cleared", 8'h00, {7'h00, irq});
    endtask : t_rx_only
    // Full duplex over phase, polarity, order and length
    task automatic t_modes();
        ssc_cfg_t   c;
        logic [7:0] m;
        logic [7:0] t;
        for (int i = 0; i < 4; i++) begin
            c = 5'h10 | 5'(i * 5);
            m = c.len7 ? 8'h7F : 8'hFF;
            t = 8'h3C ^ 8'(i * 17);
            setup(c, 8'h01);
            wr(OFS_DATA, t);
            mst.xfer(8'hC6 ^ 8'(i), c, r);
            chk("master rx", t & m, r);
            wait_irq();
            rdc("irq st", OFS_IRQ_ST, 8'h01);
            rdc("rx data", OFS_DATA, (8'hC6 ^ 8'(i)) & m);
            wr(OFS_IRQ_ST, 8'h07);
        end
    endtask : t_modes
    // Two frames unread, then flag clear
    task automatic t_overrun();
        setup(5'h00, 8'h01);
        mst.xfer(8'h5A, 5'h00, r);
        mst.xfer(8'h81, 5'h00, r);
        wait_irq();
        rdc("irq st", OFS_IRQ_ST, 8'h05);
        rdc("status", OFS_STATUS, 8'h03);
        rdc("rx data", OFS_DATA, 8'h81);
        rd(OFS_STATUS, v);
        chk("status", 8'h02, v);
        wr(OFS_FLAG_CLR, v);
        rdc("status", OFS_STATUS, 8'h00);
        wr(OFS_IRQ_ST, 8'h07);
    endtask : t_overrun
    // Continuous mode, overwrite, read-back and switch to single
    task automatic t_cont();
        logic [7:0] r2;
        setup(5'h10, 8'h03);
        wr(OFS_DATA, 8'hC3);
        rdc("irq st", OFS_IRQ_ST, 8'h02);
        wr(OFS_IRQ_ST, 8'h07);
        fork
            mst.xfer(8'h5A, 5'h10, r);
            begin
                repeat (40) @(posedge clk);
                wr(OFS_DATA, 8'h11);
                wr(OFS_DATA, 8'h96);
                rdc("tx read", OFS_DATA, 8'h96);
                rdc("status", OFS_STATUS, 8'h05);
            end
        join
        chk("master rx", 8'hC3, r);
        rdc("irq st", OFS_IRQ_ST, 8'h02);
        rdc("rx data", OFS_DATA, 8'h5A);
        wr(OFS_IRQ_ST, 8'h07);
        fork
            mst.xfer(8'h0F, 5'h10, r2);
            begin
                repeat (40) @(posedge clk);
                wr(OFS_MODE, 8'h01);
            end
        join
        chk("master rx", 8'h96, r2);
        wait_irq();
        rdc("irq st", OFS_IRQ_ST, 8'h01);
        rdc("rx data", OFS_DATA, 8'h0F);
    endtask : t_cont
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_rx_only();
        t_modes();
        t_overrun();
        t_cont();
        report_and_stop();
    end
endmodule : tb_spi_slave_rx_txrx_channel
`default_nettype wire
